// ### rtl/pacn_cn_detect.v
// Change detection: latched levels, mismatch compare, async catch for sleep
`timescale 1ns/1ns
`default_nettype none
`include "pacn_defs.vh"
module pacn_cn_detect #(
  parameter N = 24
) (
  input  wire         mclk,
  input  wire         rst_n,
  input  wire [N-1:0] cn_level,
  input  wire [N-1:0] cn_enable,
  input  wire         sleep_mode,
  input  wire         flag_clear,
  output reg          cn_flag_r
);
  reg  [N-1:0] last_r;
  reg          wake_a_r;
  reg          wake_s1_r;
  reg          wake_s2_r;
  reg          wake_s3_r;
  wire [N-1:0] diff;
  wire         any_change;
  wire         wake_pulse;

  // ------------------------------------------------------------
  // Compare present levels against last latched levels
  // ------------------------------------------------------------
  assign diff       = (cn_level ^ last_r) & cn_enable;
  assign any_change = |diff;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      last_r <= {N{1'b0}};
    end else begin
      last_r <= cn_level;
    end
  end

  // ------------------------------------------------------------
  // Clockless catch: sleep mismatch toggles a flop without mclk
  // ------------------------------------------------------------
  always @(posedge any_change or negedge rst_n) begin
    if (!rst_n) begin
      wake_a_r <= 1'b0;
    end else if (sleep_mode) begin
      wake_a_r <= ~wake_a_r;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
      wake_s3_r <= 1'b0;
    end else begin
      wake_s1_r <= wake_a_r;
      wake_s2_r <= wake_s1_r;
      wake_s3_r <= wake_s2_r;
    end
  end

  // One-cycle pulse per toggle seen after sync
  assign wake_pulse = wake_s2_r ^ wake_s3_r;

  // ------------------------------------------------------------
  // Shared sticky flag, set wins over clear
  // ------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cn_flag_r <= `PACN_FLAG_RESET;
    end else if (any_change || wake_pulse) begin
      cn_flag_r <= 1'b1;
    end else if (flag_clear) begin
      cn_flag_r <= 1'b0;
    end
  end
endmodule // pacn_cn_detect
`default_nettype wire

// ### rtl/pacn_defs.vh
// Constants for the port analog select and change notification block
`ifndef PACN_DEFS_VH
`define PACN_DEFS_VH
`define PACN_NUM_PINS      32
`define PACN_NUM_CN        24
`define PACN_HALF_W        16
`define PACN_ASEL_RESET    16'h0000
`define PACN_CN_RESET      16'h0000
`define PACN_CN_B_W        8
`define PACN_FLAG_RESET    1'b0
`endif

// ### rtl/pacn_port.v
// Port analog select, digital read masking and change notification
`timescale 1ns/1ns
`default_nettype none
`include "pacn_defs.vh"
module pacn_port #(
  parameter NP = `PACN_NUM_PINS,
  parameter NC = `PACN_NUM_CN
) (
  input  wire                    mclk,
  input  wire                    rst_n,
  input  wire [`PACN_HALF_W-1:0] a1_low_wdata,
  input  wire                    a1_low_we,
  input  wire [`PACN_HALF_W-1:0] a1_high_wdata,
  input  wire                    a1_high_we,
  input  wire [`PACN_HALF_W-1:0] a2_low_wdata,
  input  wire                    a2_low_we,
  input  wire [`PACN_HALF_W-1:0] a2_high_wdata,
  input  wire                    a2_high_we,
  input  wire                    converter1_module_disable,
  input  wire                    converter2_module_disable,
  input  wire [`PACN_HALF_W-1:0] cn_en_a_wdata,
  input  wire                    cn_en_a_we,
  input  wire [`PACN_HALF_W-1:0] cn_en_b_wdata,
  input  wire                    cn_en_b_we,
  input  wire [`PACN_HALF_W-1:0] pu_a_wdata,
  input  wire                    pu_a_we,
  input  wire [`PACN_HALF_W-1:0] pu_b_wdata,
  input  wire                    pu_b_we,
  input  wire [NP-1:0]           pin_direction_bits,
  input  wire [NP-1:0]           pin_out_level,
  input  wire [NP-1:0]           pin_in_level,
  input  wire [NC-1:0]           cn_pin_level,
  input  wire                    sleep_mode,
  input  wire                    cn_flag_clear,
  output reg  [NP-1:0]           port_read_r,
  output wire [NP-1:0]           pin_is_analog,
  output wire [NP-1:0]           conv_route_en,
  output wire [NP-1:0]           conv_digital_level,
  output wire [NP-1:0]           conv_mux_ground,
  output wire [NP-1:0]           pin_read_en,
  output wire [NC-1:0]           pullup_enable_bit,
  output wire [NC-1:0]           change_irq_enable_bit,
  output wire [`PACN_HALF_W-1:0] analog_select_low_reg,
  output wire [`PACN_HALF_W-1:0] analog_select_high_reg,
  output wire                    cn_irq
);
  reg  [`PACN_HALF_W-1:0] a1_low_r;
  reg  [`PACN_HALF_W-1:0] a1_high_r;
  reg  [`PACN_HALF_W-1:0] a2_low_r;
  reg  [`PACN_HALF_W-1:0] a2_high_r;
  reg  [`PACN_HALF_W-1:0] cn_en_a_r;
  reg  [`PACN_HALF_W-1:0] cn_en_b_r;
  reg  [`PACN_HALF_W-1:0] pu_a_r;
  reg  [`PACN_HALF_W-1:0] pu_b_r;
  wire [NP-1:0]           sel1;
  wire [NP-1:0]           sel2;
  wire [NP-1:0]           pin_analog_digital_select;
  wire [NP-1:0]           port_read_nxt;
  wire [`PACN_CN_B_W-1:0] cn_en_b_used;
  wire [`PACN_CN_B_W-1:0] pu_b_used;

  // ------------------------------------------------------------
  // Converter 1 select bits, pins 15..0
  // ------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      a1_low_r <= `PACN_ASEL_RESET;
    end else if (a1_low_we) begin
      a1_low_r <= a1_low_wdata;
    end
  end

  // ------------------------------------------------------------
  // Converter 1 select bits, pins 31..16
  // ------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      a1_high_r <= `PACN_ASEL_RESET;
    end else if (a1_high_we) begin
      a1_high_r <= a1_high_wdata;
    end
  end

  // ------------------------------------------------------------
  // Converter 2 select bits, pins 15..0
  // ------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      a2_low_r <= `PACN_ASEL_RESET;
    end else if (a2_low_we) begin
      a2_low_r <= a2_low_wdata;
    end
  end

  // ------------------------------------------------------------
  // Converter 2 select bits, pins 31..16
  // ------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      a2_high_r <= `PACN_ASEL_RESET;
    end else if (a2_high_we) begin
      a2_high_r <= a2_high_wdata;
    end
  end

  // ------------------------------------------------------------
  // Change interrupt enables, inputs 15..0
  // ------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cn_en_a_r <= `PACN_CN_RESET;
    end else if (cn_en_a_we) begin
      cn_en_a_r <= cn_en_a_wdata;
    end
  end

  // ------------------------------------------------------------
  // Change interrupt enables, inputs 23..16
  // ------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cn_en_b_r <= `PACN_CN_RESET;
    end else if (cn_en_b_we) begin
      cn_en_b_r <= {{(`PACN_HALF_W-`PACN_CN_B_W){1'b0}}, cn_en_b_wdata[`PACN_CN_B_W-1:0]};
    end
  end

  // ------------------------------------------------------------
  // Pull-up enables, inputs 15..0
  // ------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pu_a_r <= `PACN_CN_RESET;
    end else if (pu_a_we) begin
      pu_a_r <= pu_a_wdata;
    end
  end

  // ------------------------------------------------------------
  // Pull-up enables, inputs 23..16
  // ------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pu_b_r <= `PACN_CN_RESET;
    end else if (pu_b_we) begin
      pu_b_r <= {{(`PACN_HALF_W-`PACN_CN_B_W){1'b0}}, pu_b_wdata[`PACN_CN_B_W-1:0]};
    end
  end

  // ------------------------------------------------------------
  // Converter 1 stored bits shown to software
  // ------------------------------------------------------------
  assign analog_select_low_reg  = a1_low_r;
  assign analog_select_high_reg = a1_high_r;

  // ------------------------------------------------------------
  // Analog/digital selection per pin
  // ------------------------------------------------------------
  assign sel1 = {NP{converter1_module_disable}} | {a1_high_r, a1_low_r};
  assign sel2 = {NP{converter2_module_disable}} | {a2_high_r, a2_low_r};
  assign pin_analog_digital_select = sel1 & sel2;

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi = gi + 1) begin : g_pin
      assign pin_is_analog[gi]      = ~pin_analog_digital_select[gi];
      assign pin_read_en[gi]        = pin_analog_digital_select[gi];
      assign conv_mux_ground[gi]    = pin_analog_digital_select[gi];
      assign conv_route_en[gi]      = ~pin_analog_digital_select[gi];
      assign conv_digital_level[gi] = ~pin_direction_bits[gi] & pin_out_level[gi];
      assign port_read_nxt[gi]      = pin_analog_digital_select[gi] & pin_in_level[gi];
    end
  endgenerate

  // ------------------------------------------------------------
  // Port read data, one cycle behind the pins
  // ------------------------------------------------------------
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_read_r <= {NP{1'b0}};
    end else begin
      port_read_r <= port_read_nxt;
    end
  end

  // ------------------------------------------------------------
  // Change notification
  // ------------------------------------------------------------
  assign cn_en_b_used          = cn_en_b_r[`PACN_CN_B_W-1:0];
  assign pu_b_used             = pu_b_r[`PACN_CN_B_W-1:0];
  assign change_irq_enable_bit = {cn_en_b_used, cn_en_a_r};
  assign pullup_enable_bit     = {pu_b_used, pu_a_r};

  pacn_cn_detect #(
    .N (NC)
  ) u_detect (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .cn_level   (cn_pin_level),
    .cn_enable  (change_irq_enable_bit),
    .sleep_mode (sleep_mode),
    .flag_clear (cn_flag_clear),
    .cn_flag_r  (cn_irq)
  );
endmodule // pacn_port
`default_nettype wire

// ### verif/pacn_irq_host.sv
// Interrupt service model that acknowledges change requests
`timescale 1ns/1ns
`default_nettype none
module pacn_irq_host (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic cn_irq,
  input  wire logic ack_en,
  output var  logic cn_flag_clear
);
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cn_flag_clear <= 1'b0;
    end else begin
      cn_flag_clear <= cn_irq && ack_en && !cn_flag_clear;
    end
  end
endmodule // pacn_irq_host
`default_nettype wire

// ### verif/pacn_port_asserts.sv
// Checker on the port block pins
`timescale 1ns/1ns
`default_nettype none
module pacn_port_asserts #(
  parameter NP = 32,
  parameter NC = 24
) (
  input wire logic          mclk,
  input wire logic          rst_n,
  input wire logic          converter1_module_disable,
  input wire logic          converter2_module_disable,
  input wire logic          cn_en_a_we,
  input wire logic          cn_irq,
  input wire logic [15:0]   cn_en_a_wdata,
  input wire logic [15:0]   analog_select_low_reg,
  input wire logic [NP-1:0] pin_direction_bits,
  input wire logic [NP-1:0] pin_out_level,
  input wire logic [NP-1:0] port_read_r,
  input wire logic [NP-1:0] pin_is_analog,
  input wire logic [NP-1:0] conv_route_en,
  input wire logic [NP-1:0] conv_digital_level,
  input wire logic [NP-1:0] conv_mux_ground,
  input wire logic [NP-1:0] pin_read_en,
  input wire logic [NC-1:0] cn_pin_level,
  input wire logic [NC-1:0] change_irq_enable_bit
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  route_a: assert property (conv_route_en == pin_is_analog) else $error("route wrong");
  ground_mux_a:
    assert property ({conv_mux_ground, pin_read_en} == {2{~pin_is_analog}}) else $error("digital wrong");
  drive_level_a:
    assert property (conv_digital_level == (pin_out_level & ~pin_direction_bits)) else $error("level wrong");
  select_zero_a:
    assert property (!converter1_module_disable |-> &(pin_is_analog[15:0] | analog_select_low_reg)) else $error("sel");
  conv_off_a:
    assert property (converter1_module_disable && converter2_module_disable |-> pin_is_analog == 0) else $error("off");
  analog_read_a: assert property ((port_read_r & $past(pin_is_analog)) == 0) else $error("read");
  enable_load_a:
    assert property ($past(cn_en_a_we) |-> change_irq_enable_bit[15:0] == $past(cn_en_a_wdata)) else $error("en");
  change_set_a:
    assert property (((cn_pin_level ^ $past(cn_pin_level)) & change_irq_enable_bit) != 0 |-> ##[1:4] cn_irq)
      else $error("flag late");
endmodule // pacn_port_asserts
`default_nettype wire

// ### verif/pacn_port_test.sv
// Bench for the port block
`timescale 1ns/1ns
`default_nettype none
module pacn_port_test;
  logic        mclk = 1'b0, rst_n, run = 1'b1, sleep_mode = 1'b0, ack_en = 1'b0;
  logic        converter1_module_disable = 1'b0, converter2_module_disable = 1'b0;
  logic [15:0] wd = 16'h0000;
  logic [7:0]  we = 8'h00;
  logic [31:0] pin_direction_bits = 32'hFFFFFFFF, pin_out_level = 32'h00000000, pin_in_level = 32'hFFFFFFFF;
  logic [23:0] cn_pin_level = 24'h000000;
  wire  [31:0] port_read_r, pin_is_analog, conv_route_en, conv_digital_level, conv_mux_ground, pin_read_en;
  wire  [23:0] pullup_enable_bit, change_irq_enable_bit;
  wire  [15:0] analog_select_low_reg, analog_select_high_reg;
  wire         cn_irq, cn_flag_clear;
  int          error_cnt = 0, compares = 0;
  always #2 if (run) mclk = ~mclk;
  pacn_port DUT (
    .mclk                      (mclk),
    .rst_n                     (rst_n),
    .a1_low_wdata              (wd),
    .a1_low_we                 (we[0]),
    .a1_high_wdata             (wd),
    .a1_high_we                (we[1]),
    .a2_low_wdata              (wd),
    .a2_low_we                 (we[2]),
    .a2_high_wdata             (wd),
    .a2_high_we                (we[3]),
    .converter1_module_disable (converter1_module_disable),
    .converter2_module_disable (converter2_module_disable),
    .cn_en_a_wdata             (wd),
    .cn_en_a_we                (we[4]),
    .cn_en_b_wdata             (wd),
    .cn_en_b_we                (we[5]),
    .pu_a_wdata                (wd),
    .pu_a_we                   (we[6]),
    .pu_b_wdata                (wd),
    .pu_b_we                   (we[7]),
    .pin_direction_bits        (pin_direction_bits),
    .pin_out_level             (pin_out_level),
    .pin_in_level              (pin_in_level),
    .cn_pin_level              (cn_pin_level),
    .sleep_mode                (sleep_mode),
    .cn_flag_clear             (cn_flag_clear),
    .port_read_r               (port_read_r),
    .pin_is_analog             (pin_is_analog),
    .conv_route_en             (conv_route_en),
    .conv_digital_level        (conv_digital_level),
    .conv_mux_ground           (conv_mux_ground),
    .pin_read_en               (pin_read_en),
    .pullup_enable_bit         (pullup_enable_bit),
    .change_irq_enable_bit     (change_irq_enable_bit),
    .analog_select_low_reg     (analog_select_low_reg),
    .analog_select_high_reg    (analog_select_high_reg),
    .cn_irq                    (cn_irq)
  );
  pacn_irq_host HOST (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .cn_irq        (cn_irq),
    .ack_en        (ack_en),
    .cn_flag_clear (cn_flag_clear)
  );
  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input int i, input logic [15:0] d);
    @(posedge mclk) wd <= d;
    we[i] <= 1'b1;
    @(posedge mclk) we <= 8'h00;
  endtask
  task automatic print_verdict;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    rst_n <= 1'b0;
    tick(6);
    chk({analog_select_high_reg, analog_select_low_reg}, 32'h00000000);
    chk(pin_is_analog, 32'hFFFFFFFF);
    @(posedge mclk) rst_n <= 1'b1;
    $display("reset test done");
    wr(0, 16'h00FF);
    wr(1, 16'hFFFF);
    wr(2, 16'hFFFF);
    wr(3, 16'hFF00);
    tick(2);
    chk(pin_is_analog, 32'h00FFFF00);
    chk(port_read_r, 32'hFF0000FF);
    chk(conv_route_en, 32'h00FFFF00);
    chk(conv_mux_ground, 32'hFF0000FF);
    chk(pin_read_en, 32'hFF0000FF);
    @(posedge mclk) converter2_module_disable <= 1'b1;
    pin_direction_bits <= 32'hFFFF0000;
    pin_out_level <= 32'hA5A5A5A5;
    tick(1);
    chk(pin_is_analog, 32'h0000FF00);
    chk(port_read_r, 32'hFFFF00FF);
    chk(conv_digital_level, 32'h0000A5A5);
    @(posedge mclk) converter1_module_disable <= 1'b1;
    tick(1);
    chk(pin_is_analog, 32'h00000000);
    $display("select test done");
    @(posedge mclk) pin_direction_bits <= 32'hFFFFFFFF;
    wr(4, 16'h0001);
    wr(5, 16'hFF80);
    wr(6, 16'h1234);
    wr(7, 16'h0056);
    tick(1);
    chk(change_irq_enable_bit, 24'h800001);
    chk(pullup_enable_bit, 24'h561234);
    @(posedge mclk) cn_pin_level <= 24'h000020;
    tick(4);
    chk(cn_irq, 1'b0);
    @(posedge mclk) cn_pin_level <= 24'h800020;
    tick(6);
    chk(cn_irq, 1'b1);
    @(posedge mclk) ack_en <= 1'b1;
    tick(4);
    chk(cn_irq, 1'b0);
    @(posedge mclk) ack_en <= 1'b0;
    sleep_mode <= 1'b1;
    tick(2);
    run = 1'b0;
    #20 cn_pin_level = 24'h800021;
    #20 cn_pin_level = 24'h800020;
    #20 run = 1'b1;
    tick(4);
    chk(cn_irq, 1'b1);
    $display("change test done");
    print_verdict();
  end
  initial begin
    #4000;
    error_cnt++;
    print_verdict();
  end
endmodule // pacn_port_test
bind pacn_port pacn_port_asserts #(
  .NP (NP),
  .NC (NC)
) u_chk (
  .mclk                      (mclk),
  .rst_n                     (rst_n),
  .converter1_module_disable (converter1_module_disable),
  .converter2_module_disable (converter2_module_disable),
  .cn_en_a_we                (cn_en_a_we),
  .cn_irq                    (cn_irq),
  .cn_en_a_wdata             (cn_en_a_wdata),
  .analog_select_low_reg     (analog_select_low_reg),
  .pin_direction_bits        (pin_direction_bits),
  .pin_out_level             (pin_out_level),
  .port_read_r               (port_read_r),
  .pin_is_analog             (pin_is_analog),
  .conv_route_en             (conv_route_en),
  .conv_digital_level        (conv_digital_level),
  .conv_mux_ground           (conv_mux_ground),
  .pin_read_en               (pin_read_en),
  .cn_pin_level              (cn_pin_level),
  .change_irq_enable_bit     (change_irq_enable_bit)
);
`default_nettype wire
